//--- verilog/eio_pkg.sv
package eio_pkg;
  localparam int          EIO_LINES        = 32;
  localparam int          EIO_ROUTED       = 8;
  localparam int          EIO_OSEL_LINES   = 4;
  // register byte offsets
  localparam logic [7:0]  OFS_ROUTE0       = 8'h00;
  localparam logic [7:0]  OFS_OUT_SELECT   = 8'h20;
  localparam logic [7:0]  OFS_INVERT       = 8'h24;
  localparam logic [7:0]  OFS_FAST_DIR_PTR = 8'h28;
  localparam logic [7:0]  OFS_FAST_RD_PTR  = 8'h2C;
  localparam logic [7:0]  OFS_FAST_WR_PTR  = 8'h30;
  localparam logic [7:0]  OFS_ERROR_CODE   = 8'h34;
  localparam logic [7:0]  OFS_VERSION      = 8'h38;
  localparam logic [7:0]  OFS_SUB_VERSION  = 8'h3C;
  localparam logic [7:0]  OFS_LINE_BYTE    = 8'h40;
  localparam logic [7:0]  OFS_LINE_WORD    = 8'h44;
  // field positions
  localparam int          VER_MINOR_LSB    = 0;
  localparam int          VER_MAJOR_LSB    = 8;
  // reset values and error codes
  localparam logic [15:0] RST_POINTER      = 16'h0000;
  localparam logic [3:0]  RST_OUT_SELECT   = 4'h0;
  localparam logic [7:0]  RST_INVERT       = 8'h00;
  localparam logic [7:0]  ERR_NONE         = 8'h00;
  localparam logic [7:0]  ERR_OVERTEMP     = 8'h4A;
  // temperatures in degrees C
  localparam logic [7:0]  TEMP_FAN_ON_C    = 8'h55;
  localparam logic [7:0]  TEMP_FAN_OFF_C   = 8'h4B;
  localparam logic [7:0]  TEMP_TRIP_C      = 8'h5A;
  // timing
  localparam longint      CLK_HZ           = 10_000_000;
  localparam longint      FAN_MIN_S        = 10;
  localparam longint      FAN_MIN_REDUCED_S = 20;
  localparam longint      UPDATE_MS        = 4;
  localparam int          FAN_MIN_CYC      = int'(FAN_MIN_S * CLK_HZ);
  localparam int          FAN_MIN_RED_CYC  = int'(FAN_MIN_REDUCED_S * CLK_HZ);
  localparam int          UPDATE_CYC       = int'((UPDATE_MS * CLK_HZ) / 1000);

  typedef enum logic [1:0] {
    FAN_NORMAL = 2'b00,
    FAN_HOLD   = 2'b01,
    FAN_WAIT   = 2'b11
  } eio_fan_e;

  // from the host parameter system
  typedef struct packed {
    logic        dir_exists;
    logic [5:0]  dir_bits;
    logic [31:0] dir_value;
    logic        wr_exists;
    logic [5:0]  wr_bits;
    logic [31:0] wr_value;
    logic        rd_exists;
    logic [31:0] rd_max;
    logic [7:0]  route_src;
  } eio_host_in_s;

  // to the host parameter system
  typedef struct packed {
    logic [15:0] dir_ptr;
    logic [15:0] rd_ptr;
    logic [15:0] wr_ptr;
    logic [31:0] rd_value;
    logic        rd_strobe;
    logic [7:0]  route_dest;
  } eio_host_out_s;
endpackage : eio_pkg

//--- verilog/eio_line_router.sv
module eio_line_router import eio_pkg::*; #(
  parameter bit          REDUCED      = 1'b0,
  parameter int          FAN_CYC      = FAN_MIN_CYC,
  parameter int          FAN_RED_CYC  = FAN_MIN_RED_CYC,
  parameter int          UPD_CYC      = UPDATE_CYC,
  parameter logic [7:0]  VER_MAJOR    = 8'h01, // arbitrary
  parameter logic [7:0]  VER_MINOR    = 8'h00, // arbitrary
  parameter logic [7:0]  SUB_VERSION  = 8'h00  // arbitrary, 0 to 99
) (
  // clock and reset
  input  wire logic          pclk,
  input  wire logic          presetn,
  // apb slave
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [7:0]    paddr,
  input  wire logic [31:0]   pwdata,
  output logic [31:0]        prdata,
  output logic               pready,
  output logic               pslverr,
  // host parameter system
  input  wire logic          drive_reset,
  input  wire eio_host_in_s  host_in,
  output eio_host_out_s      host_out,
  // board
  input  wire logic [7:0]    board_temp_c,
  output logic               fan_full_speed,
  output logic [7:0]         error_code,
  // io lines
  input  wire logic [31:0]   io_line_i,
  output logic [31:0]        io_line_o,
  output logic [31:0]        io_line_oe_n
);

  function automatic logic [31:0] low_mask(input logic [5:0] n);
    logic [32:0] m;
    m = (33'h1 << n) - 33'h1;
    return (n >= 6'd32) ? 32'hFFFF_FFFF : m[31:0];
  endfunction : low_mask

  function automatic logic [31:0] fan_time(input bit red);
    return red ? 32'(FAN_RED_CYC) : 32'(FAN_CYC);
  endfunction : fan_time

  // software registers
  logic [15:0]   route_r [EIO_ROUTED];
  logic [15:0]   route_nxt [EIO_ROUTED];
  logic [3:0]    osel_r, osel_nxt;
  logic [7:0]    inv_r, inv_nxt;
  logic [15:0]   dptr_r, dptr_nxt, rptr_r, rptr_nxt, wptr_r, wptr_nxt;
  logic [31:0]   prdata_r, prdata_nxt;
  logic          pready_r, pready_nxt, pslverr_r, pslverr_nxt;
  logic [7:0]    subver_r, subver_nxt;
  // latched configuration
  logic [15:0]   lat_route_r [EIO_ROUTED];
  logic [15:0]   lat_route_nxt [EIO_ROUTED];
  logic          cfg_done_r, cfg_done_nxt;
  eio_host_out_s hout_r, hout_nxt;
  // pin synchronisers
  logic [31:0]   io_s1_r, io_s2_r, io_s3_r, io_q_r, io_q_nxt;
  logic [7:0]    t_s1_r, t_s2_r, t_s3_r, temp_r, temp_nxt;
  // line drive
  logic [31:0]   io_o_r, io_o_nxt, io_oe_n_r, io_oe_n_nxt;
  logic [31:0]   fdir, fwr, std_oe, std_lvl, line_oe, line_lvl, status;
  logic [31:0]   upd_cnt_r, upd_cnt_nxt;
  // thermal
  eio_fan_e      fan_st_r, fan_st_nxt;
  logic [31:0]   fan_cnt_r, fan_cnt_nxt;
  logic          fan_r, fan_nxt;
  logic [7:0]    err_r, err_nxt;
  logic          acc, wr_en, hit;

  assign acc   = psel & penable;
  assign wr_en = acc & pready_r & pwrite;

  // apb register file
  always_comb begin
    route_nxt   = route_r;
    osel_nxt    = osel_r;
    inv_nxt     = inv_r;
    dptr_nxt    = dptr_r;
    rptr_nxt    = rptr_r;
    wptr_nxt    = wptr_r;
    prdata_nxt  = 32'h0000_0000;
    pslverr_nxt = 1'b0;
    pready_nxt  = acc & ~pready_r;
    hit         = 1'b1;
    unique case (paddr)
      OFS_OUT_SELECT:   prdata_nxt = {28'h000_0000, osel_r};
      OFS_INVERT:       prdata_nxt = {24'h00_0000, inv_r};
      OFS_FAST_DIR_PTR: prdata_nxt = {16'h0000, dptr_r};
      OFS_FAST_RD_PTR:  prdata_nxt = {16'h0000, rptr_r};
      OFS_FAST_WR_PTR:  prdata_nxt = {16'h0000, wptr_r};
      OFS_ERROR_CODE:   prdata_nxt = {24'h00_0000, err_r};
      OFS_VERSION:      prdata_nxt = {16'h0000, VER_MAJOR, VER_MINOR};
      OFS_SUB_VERSION:  prdata_nxt = {24'h00_0000, subver_r};
      OFS_LINE_BYTE:    prdata_nxt = {24'h00_0000, status[7:0]};
      OFS_LINE_WORD:    prdata_nxt = status;
      default: begin
        if (paddr < OFS_OUT_SELECT && paddr[1:0] == 2'b00) begin
          prdata_nxt = {16'h0000, route_r[paddr[4:2]]};
        end else begin
          hit = 1'b0;
        end
      end
    endcase
    if (pready_r || !acc) begin
      prdata_nxt = 32'h0000_0000;
    end
    pslverr_nxt = acc & ~pready_r & ~hit;
    if (wr_en && hit) begin
      unique case (paddr)
        OFS_OUT_SELECT: begin
          osel_nxt = pwdata[3:0];
          if (REDUCED) begin
            osel_nxt[3] = 1'b0;
          end
        end
        OFS_INVERT:       inv_nxt  = pwdata[7:0];
        OFS_FAST_DIR_PTR: dptr_nxt = pwdata[15:0];
        OFS_FAST_RD_PTR:  rptr_nxt = pwdata[15:0];
        OFS_FAST_WR_PTR:  wptr_nxt = pwdata[15:0];
        default: begin
          if (paddr < OFS_OUT_SELECT) begin
            route_nxt[paddr[4:2]] = pwdata[15:0];
          end
        end
      endcase
    end
  end

  // config latched on drive reset only
  always_comb begin
    lat_route_nxt = lat_route_r;
    cfg_done_nxt  = cfg_done_r;
    hout_nxt      = hout_r;
    subver_nxt    = SUB_VERSION;
    if (drive_reset) begin
      lat_route_nxt    = route_r;
      hout_nxt.dir_ptr = dptr_r;
      hout_nxt.rd_ptr  = rptr_r;
      hout_nxt.wr_ptr  = wptr_r;
      cfg_done_nxt     = 1'b1;
    end
    hout_nxt.rd_strobe  = 1'b0;
    hout_nxt.route_dest = io_q_r[7:0] ^ inv_r;
    if (upd_cnt_r == 32'h0000_0000 && cfg_done_r
        && hout_r.rd_ptr != 16'h0000 && host_in.rd_exists) begin
      hout_nxt.rd_strobe = 1'b1;
      hout_nxt.rd_value  = (status > host_in.rd_max) ? host_in.rd_max
                                                     : status;
    end
  end

  // fast and standard line control
  always_comb begin
    fdir = 32'h0000_0000;
    fwr  = 32'h0000_0000;
    if (hout_r.dir_ptr != 16'h0000 && host_in.dir_exists) begin
      fdir = host_in.dir_value & low_mask(host_in.dir_bits);
    end
    if (hout_r.wr_ptr != 16'h0000 && host_in.wr_exists) begin
      fwr = host_in.wr_value & low_mask(host_in.wr_bits);
    end
    std_oe  = {28'h000_0000, osel_r};
    std_lvl = {24'h00_0000, host_in.route_src ^ inv_r};
    line_oe = fdir | std_oe;
    line_lvl = (fdir & fwr) | (~fdir & std_oe & std_lvl);
    if (!cfg_done_r) begin
      line_oe  = 32'h0000_0000;
      line_lvl = 32'h0000_0000;
    end
    status      = (line_oe & line_lvl) | (~line_oe & io_q_r);
    io_o_nxt    = line_lvl;
    io_oe_n_nxt = ~line_oe;
    upd_cnt_nxt = (upd_cnt_r == 32'h0000_0000) ? 32'(UPD_CYC - 1)
                                               : upd_cnt_r - 32'h0000_0001;
  end

  // pin sampling: accept when stages two and three agree
  always_comb begin
    io_q_nxt = io_q_r;
    temp_nxt = temp_r;
    for (int i = 0; i < EIO_LINES; i++) begin
      if (io_s2_r[i] == io_s3_r[i]) begin
        io_q_nxt[i] = io_s3_r[i];
      end
    end
    if (t_s2_r == t_s3_r) begin
      temp_nxt = t_s3_r;
    end
  end

  // thermal supervision and error code
  always_comb begin
    fan_st_nxt  = fan_st_r;
    fan_cnt_nxt = fan_cnt_r;
    err_nxt     = err_r;
    unique case (fan_st_r)
      FAN_NORMAL: begin
        if (temp_r > TEMP_FAN_ON_C) begin
          fan_st_nxt  = FAN_HOLD;
          fan_cnt_nxt = fan_time(REDUCED) - 32'h0000_0001;
        end
      end
      FAN_HOLD: begin
        if (temp_r > TEMP_FAN_ON_C) begin
          fan_cnt_nxt = fan_time(REDUCED) - 32'h0000_0001;
        end else if (fan_cnt_r != 32'h0000_0000) begin
          fan_cnt_nxt = fan_cnt_r - 32'h0000_0001;
        end else begin
          fan_st_nxt = FAN_WAIT;
        end
      end
      FAN_WAIT: begin
        if (temp_r > TEMP_FAN_ON_C) begin
          fan_st_nxt  = FAN_HOLD;
          fan_cnt_nxt = fan_time(REDUCED) - 32'h0000_0001;
        end else if (temp_r < TEMP_FAN_OFF_C) begin
          fan_st_nxt = FAN_NORMAL;
        end
      end
      default: fan_st_nxt = FAN_NORMAL;
    endcase
    fan_nxt = (fan_st_nxt != FAN_NORMAL);
    if (drive_reset) begin
      err_nxt = ERR_NONE;
    end
    if (temp_r > TEMP_TRIP_C) begin
      err_nxt = ERR_OVERTEMP;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < EIO_ROUTED; i++) begin
        route_r[i]     <= RST_POINTER;
        lat_route_r[i] <= RST_POINTER;
      end
      osel_r     <= RST_OUT_SELECT;
      inv_r      <= RST_INVERT;
      dptr_r     <= RST_POINTER;
      rptr_r     <= RST_POINTER;
      wptr_r     <= RST_POINTER;
      prdata_r   <= 32'h0000_0000;
      pready_r   <= 1'b0;
      pslverr_r  <= 1'b0;
      subver_r   <= 8'h00;
      cfg_done_r <= 1'b0;
      hout_r     <= '0;
      io_s1_r    <= 32'h0000_0000;
      io_s2_r    <= 32'h0000_0000;
      io_s3_r    <= 32'h0000_0000;
      io_q_r     <= 32'h0000_0000;
      t_s1_r     <= 8'h00;
      t_s2_r     <= 8'h00;
      t_s3_r     <= 8'h00;
      temp_r     <= 8'h00;
      io_o_r     <= 32'h0000_0000;
      io_oe_n_r  <= 32'hFFFF_FFFF;
      upd_cnt_r  <= 32'h0000_0000;
      fan_st_r   <= FAN_NORMAL;
      fan_cnt_r  <= 32'h0000_0000;
      fan_r      <= 1'b0;
      err_r      <= ERR_NONE;
    end else begin
      route_r     <= route_nxt;
      lat_route_r <= lat_route_nxt;
      osel_r      <= osel_nxt;
      inv_r       <= inv_nxt;
      dptr_r      <= dptr_nxt;
      rptr_r      <= rptr_nxt;
      wptr_r      <= wptr_nxt;
      prdata_r    <= prdata_nxt;
      pready_r    <= pready_nxt;
      pslverr_r   <= pslverr_nxt;
      subver_r    <= subver_nxt;
      cfg_done_r  <= cfg_done_nxt;
      hout_r      <= hout_nxt;
      io_s1_r     <= io_line_i;
      io_s2_r     <= io_s1_r;
      io_s3_r     <= io_s2_r;
      io_q_r      <= io_q_nxt;
      t_s1_r      <= board_temp_c;
      t_s2_r      <= t_s1_r;
      t_s3_r      <= t_s2_r;
      temp_r      <= temp_nxt;
      io_o_r      <= io_o_nxt;
      io_oe_n_r   <= io_oe_n_nxt;
      upd_cnt_r   <= upd_cnt_nxt;
      fan_st_r    <= fan_st_nxt;
      fan_cnt_r   <= fan_cnt_nxt;
      fan_r       <= fan_nxt;
      err_r       <= err_nxt;
    end
  end

  assign prdata         = prdata_r;
  assign pready         = pready_r;
  assign pslverr        = pslverr_r;
  assign host_out       = hout_r;
  assign fan_full_speed = fan_r;
  assign error_code     = err_r;
  assign io_line_o      = io_o_r;
  assign io_line_oe_n   = io_oe_n_r;

  // checks
  a_prelatch_all_inputs: assert property (
    @(posedge pclk) disable iff (!presetn)
    !cfg_done_r |=> (io_line_oe_n == 32'hFFFF_FFFF && io_line_o == 32'h0000_0000))
    else $error("line driven before configuration latched");
  a_ptr_latch_reset: assert property (
    @(posedge pclk) disable iff (!presetn)
    drive_reset |=> host_out.dir_ptr == $past(dptr_r) && host_out.wr_ptr == $past(wptr_r))
    else $error("pointer not latched on drive reset");
  a_ptr_hold_between: assert property (
    @(posedge pclk) disable iff (!presetn)
    !drive_reset |=> $stable(host_out.dir_ptr) && $stable(lat_route_r[0]))
    else $error("pointer changed without drive reset");
  a_err_reset_clear: assert property (
    @(posedge pclk) disable iff (!presetn)
    drive_reset && temp_r <= TEMP_TRIP_C |=> error_code == ERR_NONE)
    else $error("error code not cleared by drive reset");
  a_err_overtemp: assert property (
    @(posedge pclk) disable iff (!presetn)
    temp_r > TEMP_TRIP_C |=> error_code == ERR_OVERTEMP)
    else $error("overtemperature did not set error code");
  a_fan_force_on: assert property (
    @(posedge pclk) disable iff (!presetn)
    temp_r > TEMP_FAN_ON_C |=> fan_full_speed)
    else $error("fan not forced above threshold");
  a_fan_min_hold: assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(fan_full_speed) |-> fan_full_speed[*8])
    else $error("fan released too early");

  a_fan_release_cool: assert property (
    @(posedge pclk) disable iff (!presetn)
    $fell(fan_full_speed) |-> $past(temp_r) < TEMP_FAN_OFF_C)
    else $error("fan released while warm");

  a_line4_reduced: assert property (
    @(posedge pclk) disable iff (!presetn)
    REDUCED |-> !osel_r[3])
    else $error("line 4 select set in reduced variant");

  a_dir_null_inputs: assert property (
    @(posedge pclk) disable iff (!presetn)
    cfg_done_r && osel_r == 4'h0 && (hout_r.dir_ptr == 16'h0000 || !host_in.dir_exists)
    |=> io_line_oe_n == 32'hFFFF_FFFF)
    else $error("line driven with null direction pointer");

  a_wr_null_inactive: assert property (
    @(posedge pclk) disable iff (!presetn)
    osel_r == 4'h0 && (hout_r.wr_ptr == 16'h0000 || !host_in.wr_exists)
    |=> io_line_o == 32'h0000_0000)
    else $error("output active with null write pointer");

  a_rd_clamped: assert property (
    @(posedge pclk) disable iff (!presetn)
    hout_nxt.rd_strobe |=> host_out.rd_strobe && host_out.rd_value <= $past(host_in.rd_max))
    else $error("read word above parameter range");

  a_rd_null_silent: assert property (
    @(posedge pclk) disable iff (!presetn)
    (hout_r.rd_ptr == 16'h0000 || !host_in.rd_exists) |=> !host_out.rd_strobe)
    else $error("read word written with null pointer");

  c_fan_forced: cover property (@(posedge pclk) disable iff (!presetn) $rose(fan_full_speed));
  c_trip: cover property (@(posedge pclk) disable iff (!presetn) error_code == ERR_OVERTEMP);
  c_rd_write: cover property (@(posedge pclk) disable iff (!presetn) host_out.rd_strobe);
  c_apb_write: cover property (@(posedge pclk) disable iff (!presetn) wr_en && hit);

endmodule : eio_line_router

//--- sim/eio_host_model.sv
module eio_host_model import eio_pkg::*; (
  // clock
  input  wire logic          pclk,
  // parameter values from the bench
  input  wire eio_host_in_s  cfg,
  // block side
  input  wire eio_host_out_s host_out,
  output eio_host_in_s       host_in,
  // captured read parameter
  output logic [31:0]        rd_param,
  output int                 strobes
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = 0;
  // write value range limited to its width
  always_comb begin
    host_in          = cfg;
    host_in.wr_value = (cfg.wr_bits >= 6'd32) ? cfg.wr_value
                     : cfg.wr_value & ((32'h1 << cfg.wr_bits) - 32'h1);
  end
  // read parameter takes each strobed word
  always @(posedge pclk) begin
    if (host_out.rd_strobe === 1'b1) begin
      rd_param <= host_out.rd_value;
      cnt      <= cnt + 1;
    end
  end
  assign strobes = cnt;
endmodule : eio_host_model

//--- sim/tb_top.sv
module tb_top import eio_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  logic          pclk, presetn, psel, penable, pwrite, drive_reset, pready, pslverr;
  logic          fan_full_speed, e, fan_red;
  logic [7:0]    paddr, board_temp_c, error_code, inv;
  logic [3:0]    osel;
  logic [31:0]   pwdata, prdata, io_line_i, io_line_o, io_line_oe_n, rd_param, rd;
  logic [31:0]   prdata_red, rd_red;
  eio_host_in_s  cfg, host_in;
  eio_host_out_s host_out;
  int            strobes, fails, samples_checked, seed, s0;
  logic [7:0]    ra [8] = '{8'h20, 8'h24, 8'h28, 8'h2C, 8'h30, 8'h34, 8'h38, 8'h3C};
  logic [31:0]   rv [8] = '{0, 0, 0, 0, 0, 0, 32'h0000_0100, 0};

  eio_line_router #(.FAN_CYC(20), .FAN_RED_CYC(40), .UPD_CYC(8)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .drive_reset(drive_reset), .host_in(host_in),
    .host_out(host_out), .board_temp_c(board_temp_c), .fan_full_speed(fan_full_speed),
    .error_code(error_code), .io_line_i(io_line_i), .io_line_o(io_line_o),
    .io_line_oe_n(io_line_oe_n));

  // reduced variant on the same bus and pins
  eio_line_router #(.REDUCED(1'b1), .FAN_CYC(20), .FAN_RED_CYC(40), .UPD_CYC(8)) dut_red (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata_red), .pready(), .pslverr(),
    .drive_reset(drive_reset), .host_in(host_in), .host_out(),
    .board_temp_c(board_temp_c), .fan_full_speed(fan_red), .error_code(),
    .io_line_i(io_line_i), .io_line_o(), .io_line_oe_n());

  eio_host_model hm (.pclk(pclk), .cfg(cfg), .host_out(host_out), .host_in(host_in),
    .rd_param(rd_param), .strobes(strobes));

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task automatic give_verdict();
    $display("fails=%0d samples_checked=%0d", fails, samples_checked);
    if (fails == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    samples_checked++;
    if (got !== want) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, got, want);
    end
  endtask : chk

  task automatic cyc(input int k);
    repeat (k) @(posedge pclk);
  endtask : cyc

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    rd_red = prdata_red;
    e  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      fails++;
      $display("unexpected at %0t: no pready", $time);
      give_verdict();
    end
  endtask : apb

  task automatic pulse_reset();
    @(posedge pclk);
    drive_reset <= 1'b1;
    @(posedge pclk);
    drive_reset <= 1'b0;
    cyc(2);
  endtask : pulse_reset

  function automatic logic [31:0] lim(input logic [5:0] b);
    return (b >= 6'd32) ? 32'hffff_ffff : (32'h1 << b) - 32'h1;
  endfunction : lim

  function automatic logic [31:0] fdir();
    return cfg.dir_exists ? cfg.dir_value & lim(cfg.dir_bits) : 32'h0;
  endfunction : fdir

  function automatic logic [31:0] outs();
    return fdir() | {28'h0, osel};
  endfunction : outs

  function automatic logic [31:0] lvl();
    logic [31:0] w;
    w = cfg.wr_exists ? cfg.wr_value & lim(cfg.wr_bits) : 32'h0;
    return (fdir() & w) | (~fdir() & {24'h0, cfg.route_src ^ inv});
  endfunction : lvl

  function automatic logic [31:0] rdx();
    logic [31:0] st;
    st = (lvl() & outs()) | (io_line_i & ~outs());
    return (st > cfg.rd_max) ? cfg.rd_max : st;
  endfunction : rdx

  task automatic chk_lines();
    cyc(10);
    chk(~io_line_oe_n, outs());
    chk(io_line_o & outs(), lvl() & outs());
  endtask : chk_lines

  initial begin
    seed            = 32'hee64de11;
    fails           = 0;
    samples_checked = 0;
    presetn         = 1'b0;
    psel            = 1'b0;
    penable         = 1'b0;
    pwrite          = 1'b0;
    paddr           = 8'h00;
    pwdata          = 32'h0000_0000;
    drive_reset     = 1'b0;
    board_temp_c    = 8'h19;
    io_line_i       = 32'h0000_0000;
    cfg             = '0;
    osel            = 4'h0;
    inv             = 8'h00;
    cyc(3);
    presetn <= 1'b1;
    foreach (ra[i]) begin
      apb(1'b0, ra[i], 32'h0);
      chk(rd, rv[i]);
    end
    apb(1'b0, 8'hFC, 32'h0);
    chk({31'h0, e}, 32'h1);
    apb(1'b1, OFS_SUB_VERSION, 32'h63);
    apb(1'b0, OFS_SUB_VERSION, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, OFS_FAST_DIR_PTR, 32'h1415);
    apb(1'b1, OFS_FAST_RD_PTR, 32'h1416);
    apb(1'b1, OFS_FAST_WR_PTR, 32'h1417);
    apb(1'b1, OFS_ROUTE0 + 8'h1C, 32'h0A0B);
    apb(1'b0, OFS_ROUTE0 + 8'h1C, 32'h0);
    chk(rd, 32'h0A0B);
    chk({16'h0, host_out.dir_ptr}, 32'h0);
    chk(io_line_oe_n, 32'hffff_ffff);
    pulse_reset();
    chk({host_out.dir_ptr, host_out.wr_ptr}, 32'h1415_1417);
    chk({16'h0000, host_out.rd_ptr}, 32'h0000_1416);
    apb(1'b1, OFS_FAST_DIR_PTR, 32'h0);
    cyc(3);
    chk({16'h0, host_out.dir_ptr}, 32'h1415);
    for (int i = 0; i < 10; i++) begin
      s0 = $random(seed);
      cfg.dir_exists <= s0[0] | s0[1];
      cfg.wr_exists  <= s0[2] | s0[3];
      cfg.rd_exists  <= s0[4] | s0[5];
      cfg.dir_bits   <= 6'(s0[13:8] % 33);
      cfg.wr_bits    <= 6'(s0[21:16] % 33);
      cfg.dir_value  <= $random(seed);
      cfg.wr_value   <= $random(seed);
      cfg.rd_max     <= s0[6] ? 32'hffff_ffff : $random(seed) & 32'h0000_ffff;
      cfg.route_src  <= $random(seed);
      io_line_i      <= $random(seed);
      if (i == 0) begin
        cfg             <= '0;
        cfg.dir_exists  <= 1'b1;
        cfg.wr_exists   <= 1'b1;
        cfg.rd_exists   <= 1'b1;
        cfg.dir_bits    <= 6'd32;
        cfg.wr_bits     <= 6'd32;
        cfg.dir_value   <= 32'd29;
        cfg.wr_value    <= 32'd23;
        cfg.rd_max      <= 32'hffff_ffff;
        io_line_i       <= 32'h0;
      end
      chk_lines();
      s0 = strobes;
      cyc(20);
      if (cfg.rd_exists) chk(rd_param, rdx());
      else chk(strobes - s0, 32'h0);
    end
    cfg.dir_exists <= 1'b0;
    osel = 4'hA;
    inv  = 8'h0F;
    apb(1'b1, OFS_OUT_SELECT, {28'h0, osel});
    apb(1'b1, OFS_INVERT, {24'h0, inv});
    apb(1'b0, OFS_OUT_SELECT, 32'h0000_0000);
    chk(rd, {28'h000_0000, osel});
    chk(rd_red, {28'h000_0000, 1'b0, osel[2:0]});
    chk_lines();
    osel = 4'h0;
    apb(1'b1, OFS_OUT_SELECT, 32'h0);
    io_line_i <= $random(seed);
    cyc(10);
    apb(1'b0, OFS_LINE_BYTE, 32'h0);
    chk(rd, {24'h0, io_line_i[7:0]});
    chk({24'h00_0000, host_out.route_dest}, {24'h00_0000, io_line_i[7:0] ^ inv});
    apb(1'b0, OFS_LINE_WORD, 32'h0);
    chk(rd, io_line_i);
    board_temp_c <= 8'd86;
    cyc(2);
    board_temp_c <= 8'd70;
    cyc(12);
    chk({31'h0, fan_full_speed}, 32'h1);
    cyc(30);
    chk({31'h0, fan_full_speed}, 32'h0);
    chk({31'h0, fan_red}, 32'h0000_0001);
    board_temp_c <= 8'd86;
    cyc(8);
    board_temp_c <= 8'd80;
    cyc(40);
    chk({31'h0, fan_full_speed}, 32'h1);
    board_temp_c <= 8'd91;
    cyc(8);
    apb(1'b0, OFS_ERROR_CODE, 32'h0);
    chk(rd, 32'd74);
    board_temp_c <= 8'd25;
    cyc(8);
    pulse_reset();
    chk({24'h0, error_code}, 32'h0);
    chk(io_line_oe_n, 32'hffff_ffff);
    give_verdict();
  end
endmodule : tb_top
